// ===== rtl/exc_int_defs.svh
// Offsets, field positions, codes and reset values for the exception unit.
// Summary of operation
// - Undefined major or group minor opcodes raise reserved-instruction.
// - Wide ops reserved in 32-bit user/supervisor mode; kernel allows them.
// - All five exceptions use the common vector with distinct cause codes.
// - Return pc is faulting pc, or branch pc with delay-slot flag set.
// - Unusable coprocessor faults; unit zero only outside kernel mode.
// - Coprocessor-error field records which of units 0, 1 and 2 was referenced.
// - Float exception follows the float status register and clears with it.
// - Selected load/store hits on the watch address; cache ops never hit.
// - Watch waits while exception level is set; interrupt, unusable, reserved and float exceptions win over it.
// - Pending bits ANDed with masks, ORed, then ANDed with global enable.
// - Pending field shows live requests and latches nothing.
// - Soft bits hold until written zero; hardware bits follow sources.
// - Hardware interrupt pins are registered on every rising clock edge.
// - Writes with address bits 6:4 zero reach the write-only register.
// - Data bits 22 and 20:16 enable writing values from bits 6, 4:0.
// - Timer interrupt appears as pending bit 7, cause bit 15.
// - Register bits 4:0 ORed with inverted pins form cause bits 14:10.
// - Non-maskable level is inverted pin OR bit 6; taken on rising edge.
// - Unmasked pending sources raise the interrupt exception; non-maskable only pulses nmiTaken; none has priority.
`ifndef EXC_INT_DEFS_SVH
`define EXC_INT_DEFS_SVH
`define OFF_STATUS   12'h000
`define OFF_CAUSE    12'h004
`define OFF_EPC      12'h008
`define OFF_WATCH_LO 12'h00C
`define OFF_WATCH_HI 12'h010
`define OFF_FP_CSR   12'h014
`define STATUS_RST   32'h0000_0000
`define STATUS_WMASK 32'hF000_FFBB
`define ST_IE        0
`define ST_EXL       1
`define ST_MODE_LO   3
`define ST_WIDE      5
`define ST_KWIDE     7
`define ST_IM_LO     8
`define ST_CU_LO     28
`define CA_SOFT_LO   8
`define FP_EN_LO     7
`define FP_CAUSE_LO  12
`define EXT_SEL      3'h0
`define EXT_EN_NMI   22
`define EXT_EN_LO    16
`define EXT_VAL_NMI  6
`define EXC_INT      5'h00
`define EXC_RI       5'h0A
`define EXC_CPU      5'h0B
`define EXC_FPE      5'h0F
`define EXC_WATCH    5'h17
`define OP_FUNCTION_GROUP_OPCODE   6'h00
`define OP_REG_IMMEDIATE_GROUP    6'h01
`define OP_COP1X     6'h13
`define MAJOR_DEF    64'hF7FF_FFFF_0FFF_FFFF
`define SPEC_DEF     64'hDD5F_FCFF_FFDF_BFDF
`define REG_IMMEDIATE_GROUP_DEF   32'h000F_5F0F
`define MAJOR_64     64'h9090_0080_0F00_0000
`define SPEC_64      64'hDD00_F000_F0D0_0000
`endif

// ===== rtl/exc_int_pkg.sv
// Types shared by the exception unit.
package exc_int_pkg;
	typedef enum logic [1:0] {
		MODE_KERNEL,
		MODE_SUPER,
		MODE_USER,
		MODE_RSVD
	} priv_mode_t;
endpackage

// ===== rtl/exception_interrupt_logic.sv
// Exception detection, interrupt combining and APB register file.
`timescale 1ns/10ps
`include "exc_int_defs.svh"
module exception_interrupt_logic #(
	parameter int unsigned ADDR_W = 12
)(
	input  wire logic              sys_clk,
	input  wire logic              rst,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic [31:0]       pwdata,
	output logic      [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr,
	input  wire logic              instrValid,
	input  wire logic [31:0]       instrWord,
	input  wire logic [31:0]       instrPc,
	input  wire logic              instrInSlot,
	input  wire logic [31:0]       branchPc,
	input  wire logic              memValid,
	input  wire logic              memLoad,
	input  wire logic              memStore,
	input  wire logic              memCache,
	input  wire logic [35:0]       memPaddr,
	input  wire logic [5:0]        fpCauseSet,
	input  wire logic [4:0]        intPinN,
	input  wire logic              nmiN,
	input  wire logic              timerInt,
	input  wire logic              extWrValid,
	input  wire logic [2:0]        extWrAddr,
	input  wire logic [31:0]       extWrData,
	output logic                   excTaken,
	output logic      [4:0]        excCode,
	output logic                   intRequest,
	output logic                   nmiTaken,
	output logic                   fpExcPending
);

	localparam logic [63:0] MAJOR_DEF  = `MAJOR_DEF;
	localparam logic [63:0] SPEC_DEF   = `SPEC_DEF;
	localparam logic [31:0] REG_IMMEDIATE_GROUP_DEF = `REG_IMMEDIATE_GROUP_DEF;
	localparam logic [63:0] MAJOR_64   = `MAJOR_64;
	localparam logic [63:0] SPEC_64    = `SPEC_64;

	logic [31:0] status_q;
	logic [1:0]  soft_q;
	logic        bd_q;
	logic [1:0]  ce_q;
	logic [4:0]  code_q;
	logic [31:0] epc_q;
	logic [31:0] watch_addr_low_q;
	logic [3:0]  watch_addr_high_q;
	logic [5:0]  fpCause_q;
	logic [4:0]  fpEn_q;
	logic [4:0]  pinN_q;
	logic        nmiN_q;
	logic        nmiPrev_q;
	logic [5:0]  extInt_q;
	logic        watchPend_q;
	logic [7:0]  ip;
	logic        intReq;
	logic        nmiLevel;
	logic        exception_level_bit;
	logic        acc;
	logic        wrAcc;
	logic        mapped;
	logic [31:0] rdVal;
	logic        extSel;
	logic        fpTrap;
	logic        watchHit;
	logic        watchNow;
	logic        intTake;
	logic        riHit;
	logic        cuHit;
	logic        fpHit;
	logic        copInstr;
	logic [1:0]  cuUnit;
	logic        take;
	logic [4:0]  takeCode;
	logic [5:0]  op;
	exc_int_pkg::priv_mode_t mode;

	// ----------------------------------------------------------------
	// Pin sampling and external interrupt register
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			pinN_q    <= 5'h1F;
			nmiN_q    <= 1'b1;
			nmiPrev_q <= 1'b0;
		end else begin
			pinN_q    <= intPinN;
			nmiN_q    <= nmiN;
			nmiPrev_q <= nmiLevel;
		end
	end

	assign extSel = extWrValid && extWrAddr == `EXT_SEL;

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			extInt_q <= 6'h00;
		end else if (extSel) begin
			for (int i = 0; i < 5; i++) begin
				if (extWrData[`EXT_EN_LO+i]) begin
					extInt_q[i] <= extWrData[i];
				end
			end
			if (extWrData[`EXT_EN_NMI]) begin
				extInt_q[5] <= extWrData[`EXT_VAL_NMI];
			end
		end
	end

	// ----------------------------------------------------------------
	// Interrupt combining
	// ----------------------------------------------------------------
	// Live, unlatched pending field; no source is ranked above another.
	assign ip[7]   = timerInt;
	assign ip[6:2] = extInt_q[4:0] | ~pinN_q;
	assign ip[1:0] = soft_q;
	assign intReq  = (|(ip & status_q[`ST_IM_LO+:8]))
	                 && status_q[`ST_IE];
	assign nmiLevel = ~nmiN_q | extInt_q[5];
	assign exception_level_bit      = status_q[`ST_EXL];
	assign mode     = exc_int_pkg::priv_mode_t'(status_q[`ST_MODE_LO+:2]);

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			intRequest <= 1'b0;
			nmiTaken   <= 1'b0;
		end else begin
			intRequest <= intReq;
			nmiTaken   <= nmiLevel && !nmiPrev_q;
		end
	end

	// ----------------------------------------------------------------
	// Exception detection
	// ----------------------------------------------------------------
	assign op     = instrWord[31:26];
	assign fpTrap = fpCause_q[5] || |(fpCause_q[4:0] & fpEn_q);

	always_comb begin
		copInstr = op[5:2] == 4'b0100 || (op[5:4] == 2'b11
		           && (op[1:0] == 2'b01 || op[1:0] == 2'b10));
		cuUnit = (op == `OP_COP1X) ? 2'd1 : op[1:0];
		cuHit  = copInstr && !status_q[`ST_CU_LO+cuUnit]
		         && (cuUnit != 2'd0
		         || mode != exc_int_pkg::MODE_KERNEL);
		riHit = !MAJOR_DEF[op]
		        || (op == `OP_FUNCTION_GROUP_OPCODE && !SPEC_DEF[instrWord[5:0]])
		        || (op == `OP_REG_IMMEDIATE_GROUP
		        && !REG_IMMEDIATE_GROUP_DEF[instrWord[20:16]]);
		if ((MAJOR_64[op] || (op == `OP_FUNCTION_GROUP_OPCODE
		    && SPEC_64[instrWord[5:0]]))
		    && mode != exc_int_pkg::MODE_KERNEL
		    && !status_q[`ST_WIDE]) begin
			riHit = 1'b1;
		end
		fpHit = fpTrap && copInstr && cuUnit == 2'd1
		        && status_q[`ST_CU_LO+1];
	end

	assign watchHit = memValid && !memCache
	                  && ((memLoad && watch_addr_low_q[1])
	                  || (memStore && watch_addr_low_q[0]))
	                  && memPaddr[35:3]
	                  == {watch_addr_high_q, watch_addr_low_q[31:3]};
	assign watchNow = (watchHit || watchPend_q) && !exception_level_bit;
	assign intTake  = intReq && !exception_level_bit;

	always_comb begin
		take     = instrValid;
		takeCode = `EXC_INT;
		if (intTake) begin
			takeCode = `EXC_INT;
		end else if (cuHit) begin
			takeCode = `EXC_CPU;
		end else if (riHit) begin
			takeCode = `EXC_RI;
		end else if (fpHit) begin
			takeCode = `EXC_FPE;
		end else if (watchNow) begin
			takeCode = `EXC_WATCH;
		end else begin
			take = 1'b0;
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			watchPend_q <= 1'b0;
		end else if (watchHit && exception_level_bit) begin
			watchPend_q <= 1'b1;
		end else if (take && takeCode == `EXC_WATCH) begin
			watchPend_q <= 1'b0;
		end
	end

	// Every exception here leaves through the common vector.
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			excTaken <= 1'b0;
			excCode  <= 5'h00;
			code_q   <= 5'h00;
			epc_q    <= 32'h0000_0000;
			bd_q     <= 1'b0;
			ce_q     <= 2'h0;
		end else begin
			excTaken <= take;
			if (take) begin
				excCode <= takeCode;
				code_q  <= takeCode;
				epc_q   <= instrInSlot ? branchPc : instrPc;
				bd_q    <= instrInSlot;
				if (takeCode == `EXC_CPU) begin
					ce_q <= cuUnit;
				end
			end else if (wrAcc && paddr == `OFF_EPC) begin
				epc_q <= pwdata;
			end
		end
	end

	// ----------------------------------------------------------------
	// APB slave
	// ----------------------------------------------------------------
	assign acc   = psel && penable && pready;
	assign wrAcc = acc && pwrite;

	always_comb begin
		mapped = 1'b1;
		case (paddr)
			`OFF_STATUS:   rdVal = status_q;
			`OFF_CAUSE:    rdVal = {bd_q, 1'b0, ce_q, 12'h000, ip,
			                        1'b0, code_q, 2'b00};
			`OFF_EPC:      rdVal = epc_q;
			`OFF_WATCH_LO: rdVal = watch_addr_low_q;
			`OFF_WATCH_HI: rdVal = {28'h0000000, watch_addr_high_q};
			`OFF_FP_CSR:   rdVal = {14'h0000, fpCause_q, fpEn_q,
			                        7'h00};
			default: begin
				rdVal  = 32'h0000_0000;
				mapped = 1'b0;
			end
		endcase
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end else begin
			pready  <= psel && penable && !pready;
			pslverr <= psel && penable && !pready && !mapped;
			if (psel && penable && !pready && !pwrite) begin
				prdata <= rdVal;
			end
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			status_q <= `STATUS_RST;
		end else begin
			if (wrAcc && paddr == `OFF_STATUS) begin
				status_q <= pwdata & `STATUS_WMASK;
			end
			if (take) begin
				status_q[`ST_EXL] <= 1'b1;
			end
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			soft_q <= 2'b00;
		end else if (wrAcc && paddr == `OFF_CAUSE) begin
			soft_q <= pwdata[`CA_SOFT_LO+:2];
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			watch_addr_low_q <= 32'h0000_0000;
			watch_addr_high_q <= 4'h0;
		end else if (wrAcc) begin
			if (paddr == `OFF_WATCH_LO) begin
				watch_addr_low_q <= pwdata & 32'hFFFF_FFFB;
			end
			if (paddr == `OFF_WATCH_HI) begin
				watch_addr_high_q <= pwdata[3:0];
			end
		end
	end

	// A cause raised by the float unit in the clearing cycle survives.
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			fpCause_q    <= 6'h00;
			fpEn_q       <= 5'h00;
			fpExcPending <= 1'b0;
		end else begin
			fpExcPending <= fpTrap;
			if (wrAcc && paddr == `OFF_FP_CSR) begin
				fpCause_q <= pwdata[`FP_CAUSE_LO+:6] | fpCauseSet;
				fpEn_q    <= pwdata[`FP_EN_LO+:5];
			end else begin
				fpCause_q <= fpCause_q | fpCauseSet;
			end
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);

	ext_write_a: assert property (
		extSel && extWrData[16] |=> extInt_q[0] == $past(extWrData[0]))
		else $error("Interrupt register bit 0 not written.");

	ext_select_a: assert property (
		!extSel |=> $stable(extInt_q))
		else $error("Interrupt register changed without selection.");

	int_enable_a: assert property (
		!status_q[`ST_IE] |=> !intRequest)
		else $error("Interrupt request with global enable clear.");

	pin_pending_a: assert property (
		!intPinN[0] |=> ip[2])
		else $error("Low pin 0 not shown in pending field.");

	timer_pending_a: assert property (
		timerInt && status_q[`ST_IM_LO+7] && status_q[`ST_IE]
		|=> intRequest)
		else $error("Timer request not raised as interrupt.");

	nmi_edge_a: assert property (
		nmiTaken |-> $past(nmiLevel) && !$past(nmiPrev_q)
		##1 !nmiTaken)
		else $error("Non-maskable interrupt without assertion edge.");

	watch_defer_a: assert property (
		excTaken && excCode == `EXC_WATCH |-> !$past(exception_level_bit))
		else $error("Watch exception taken at exception level.");

	slot_epc_a: assert property (
		take && instrInSlot |=> epc_q == $past(branchPc) && bd_q)
		else $error("Delay-slot exception pc wrong.");

	kernel_cop0_a: assert property (
		instrValid && op == 6'h10 && mode == exc_int_pkg::MODE_KERNEL
		|=> !(excTaken && excCode == `EXC_CPU))
		else $error("Kernel unit zero access flagged unusable.");

	soft_hold_a: assert property (
		!(wrAcc && paddr == `OFF_CAUSE) |=> $stable(soft_q))
		else $error("Soft interrupt bits changed without a write.");

	undef_op_a: assert property (
		instrValid && op == 6'h1D && !intTake && !cuHit
		|=> excTaken && excCode == `EXC_RI)
		else $error("Undefined opcode not reported.");

	nmi_c: cover property (nmiTaken);
	watch_c: cover property (excTaken && excCode == `EXC_WATCH);
	int_c: cover property (excTaken && excCode == `EXC_INT);
	ext_c: cover property (extSel ##1 intRequest);

endmodule

// ===== bench/board_agent.sv
// Board interrupt sources and external write agent.
`timescale 1ns/10ps
module board_agent (
	input  wire logic        sys_clk,
	output logic      [4:0]  intPinN,
	output logic             nmiN,
	output logic             timerInt,
	output logic             extWrValid,
	output logic      [2:0]  extWrAddr,
	output logic      [31:0] extWrData
);
	initial begin
		intPinN = 5'h1F;
		nmiN = 1'b1;
		timerInt = 1'b0;
		extWrValid = 1'b0;
		extWrAddr = 3'h7;
		extWrData = 32'h0000_0000;
	end
	// One data cycle, then the released bus shows the inverse.
	task automatic ext_write(input logic [2:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		extWrValid <= 1'b1;
		extWrAddr <= a;
		extWrData <= d;
		@(posedge sys_clk);
		extWrValid <= 1'b0;
		extWrAddr <= ~a;
		extWrData <= ~d;
	endtask
	// Levels stay until the next set_levels call changes them.
	task automatic set_levels(input logic [4:0] p, input logic n,
		input logic t);
		@(posedge sys_clk);
		intPinN <= p;
		nmiN <= n;
		timerInt <= t;
	endtask
endmodule

// ===== bench/tb_exception_interrupt_logic.sv
// Self-checking bench for the exception and interrupt unit.
`timescale 1ns/10ps
`include "exc_int_defs.svh"
`define CHK(nm, ex, gt) begin check_count++; if ((gt) !== (ex)) begin \
	err_count++; $display("[FAIL] %s exp %h got %h", nm, ex, gt); end end
module tb_exception_interrupt_logic;
	logic        sys_clk = 1'b0;
	logic        rst, psel, penable, pwrite, pready, pslverr, sl;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd, instrWord, instrPc, branchPc;
	logic        instrValid, instrInSlot, memValid, memLoad, memStore;
	logic        memCache, timerInt, nmiN, extWrValid;
	logic [35:0] memPaddr;
	logic [5:0]  fpCauseSet;
	logic [4:0]  intPinN, excCode;
	logic [2:0]  extWrAddr;
	logic [31:0] extWrData;
	logic        excTaken, intRequest, nmiTaken, fpExcPending;
	logic [31:0] riw [3] = '{32'h7400_0000, 32'h0000_0005, 32'h0404_0000};
	int          err_count = 0;
	int          check_count = 0;

	always #2.5 sys_clk = ~sys_clk;

	board_agent agent (.sys_clk(sys_clk), .intPinN(intPinN), .nmiN(nmiN),
		.timerInt(timerInt), .extWrValid(extWrValid),
		.extWrAddr(extWrAddr), .extWrData(extWrData));

	exception_interrupt_logic dut (.sys_clk(sys_clk), .rst(rst),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .instrValid(instrValid), .instrWord(instrWord),
		.instrPc(instrPc), .instrInSlot(instrInSlot), .branchPc(branchPc),
		.memValid(memValid), .memLoad(memLoad), .memStore(memStore),
		.memCache(memCache), .memPaddr(memPaddr), .fpCauseSet(fpCauseSet),
		.intPinN(intPinN), .nmiN(nmiN), .timerInt(timerInt),
		.extWrValid(extWrValid), .extWrAddr(extWrAddr),
		.extWrData(extWrData), .excTaken(excTaken), .excCode(excCode),
		.intRequest(intRequest), .nmiTaken(nmiTaken),
		.fpExcPending(fpExcPending));

	task automatic conclude();
		$display("checks %0d errors %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		@(posedge sys_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		do begin
			@(posedge sys_clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1)
			err_count++;
		rd = prdata;
		sl = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rchk(input string nm, input logic [11:0] a,
		input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		`CHK(nm, e, rd)
	endtask

	task automatic st(input logic [31:0] d);
		apb(1'b1, `OFF_STATUS, d);
	endtask

	task automatic settle();
		repeat (2) @(posedge sys_clk);
		#1;
	endtask

	task automatic ins(input logic [31:0] w, input logic s, input logic e,
		input logic [4:0] c);
		@(posedge sys_clk);
		instrValid <= 1'b1;
		instrWord <= w;
		instrInSlot <= s;
		@(posedge sys_clk);
		instrValid <= 1'b0;
		memValid <= 1'b0;
		#1;
		`CHK("excTaken", e, excTaken)
		if (e)
			`CHK("excCode", c, excCode)
	endtask

	task automatic pulses(input int ex);
		int k;
		k = 0;
		repeat (6) begin
			@(posedge sys_clk);
			#1;
			if (nmiTaken !== 1'b0)
				k++;
		end
		`CHK("nmiTaken", ex, k)
	endtask

	initial begin
		#200000;
		err_count++;
		conclude();
	end

	initial begin
		{rst, psel, penable, pwrite, instrValid, instrInSlot} = 6'h20;
		{memValid, memLoad, memStore, memCache} = 4'h0;
		{paddr, pwdata, instrWord, memPaddr, fpCauseSet} = '0;
		instrPc = 32'h0000_0400;
		branchPc = 32'h0000_03FC;
		repeat (4) @(posedge sys_clk);
		rst <= 1'b0;
		rchk("cause", `OFF_CAUSE, 32'h0);
		apb(1'b0, 12'hFFC, 32'h0);
		`CHK("pslverr", 1'b1, sl)
		agent.ext_write(3'h1, 32'h001F_001F);
		rchk("cause", `OFF_CAUSE, 32'h0);
		agent.ext_write(3'h0, 32'h001F_001F);
		rchk("cause", `OFF_CAUSE, 32'h7C00);
		agent.ext_write(3'h0, 32'h0005_0000);
		rchk("cause", `OFF_CAUSE, 32'h6800);
		st(32'h0800);
		settle();
		`CHK("intRequest", 1'b0, intRequest)
		st(32'h0801);
		settle();
		`CHK("intRequest", 1'b1, intRequest)
		ins(32'h0, 1'b0, 1'b1, `EXC_INT);
		st(32'h0401);
		settle();
		`CHK("intRequest", 1'b0, intRequest)
		agent.ext_write(3'h0, 32'h001F_0000);
		agent.set_levels(5'h1A, 1'b1, 1'b0);
		rchk("cause", `OFF_CAUSE, 32'h1400);
		agent.set_levels(5'h1F, 1'b1, 1'b1);
		rchk("cause", `OFF_CAUSE, 32'h8000);
		st(32'h8001);
		settle();
		`CHK("intRequest", 1'b1, intRequest)
		agent.set_levels(5'h1F, 1'b1, 1'b0);
		apb(1'b1, `OFF_CAUSE, 32'h0300);
		st(32'h0101);
		settle();
		`CHK("intRequest", 1'b1, intRequest)
		rchk("cause", `OFF_CAUSE, 32'h0300);
		apb(1'b1, `OFF_CAUSE, 32'h0);
		st(32'h0);
		rchk("cause", `OFF_CAUSE, 32'h0);
		agent.set_levels(5'h1F, 1'b0, 1'b0);
		pulses(1);
		agent.set_levels(5'h1F, 1'b1, 1'b0);
		pulses(0);
		agent.ext_write(3'h0, 32'h0040_0040);
		pulses(1);
		agent.ext_write(3'h0, 32'h0040_0000);
		foreach (riw[i]) begin
			ins(riw[i], 1'b0, 1'b1, `EXC_RI);
			st(32'h0);
		end
		rchk("epc", `OFF_EPC, 32'h0400);
		ins(32'h7400_0000, 1'b1, 1'b1, `EXC_RI);
		rchk("epc", `OFF_EPC, 32'h03FC);
		rchk("cause", `OFF_CAUSE, 32'h8000_0028);
		st(32'h10);
		ins(32'h0000_002C, 1'b0, 1'b1, `EXC_RI);
		st(32'h0);
		ins(32'h0000_002C, 1'b0, 1'b0, `EXC_RI);
		st(32'h08);
		ins(32'h0000_002C, 1'b0, 1'b1, `EXC_RI);
		st(32'h28);
		ins(32'h0000_002C, 1'b0, 1'b0, `EXC_RI);
		st(32'h0);
		for (int u = 1; u < 3; u++) begin
			ins(32'h4000_0000 | (u << 26), 1'b0, 1'b1, `EXC_CPU);
			rchk("cause", `OFF_CAUSE, 32'h2C | (u << 28));
			st(32'h0);
		end
		ins(32'h4000_0000, 1'b0, 1'b0, `EXC_CPU);
		st(32'h10);
		ins(32'h4000_0000, 1'b0, 1'b1, `EXC_CPU);
		rchk("cause", `OFF_CAUSE, 32'h0000_002C);
		st(32'h2000_0000);
		ins(32'h4400_0000, 1'b0, 1'b0, `EXC_CPU);
		apb(1'b1, `OFF_FP_CSR, 32'h0800);
		fpCauseSet <= 6'h10;
		@(posedge sys_clk);
		fpCauseSet <= 6'h00;
		settle();
		`CHK("fpExcPending", 1'b1, fpExcPending)
		ins(32'h4400_0000, 1'b0, 1'b1, `EXC_FPE);
		st(32'h2000_0000);
		apb(1'b1, `OFF_FP_CSR, 32'h0800);
		settle();
		`CHK("fpExcPending", 1'b0, fpExcPending)
		st(32'h0);
		apb(1'b1, `OFF_WATCH_LO, 32'h0000_1002);
		memPaddr <= 36'h0_0000_1000;
		{memValid, memLoad} <= 2'h3;
		ins(32'h8C00_0000, 1'b0, 1'b1, `EXC_WATCH);
		st(32'h0);
		{memValid, memCache} <= 2'h3;
		ins(32'hBC00_0000, 1'b0, 1'b0, `EXC_WATCH);
		{memValid, memCache, memLoad, memStore} <= 4'h9;
		ins(32'hAC00_0000, 1'b0, 1'b0, `EXC_WATCH);
		{memLoad, memStore} <= 2'h2;
		st(32'h2);
		memValid <= 1'b1;
		ins(32'h8C00_0000, 1'b0, 1'b0, `EXC_WATCH);
		st(32'h0);
		ins(32'h0, 1'b0, 1'b1, `EXC_WATCH);
		conclude();
	end
endmodule
